// *** hdl/csl_pkg.sv ***
package csl_pkg;
  // serial word width, fixed by the codec's word-size strap
  localparam int unsigned CSL_WORD_W = 16;
  // register byte offsets
  localparam logic [7:0] CSL_OFF_GCTL = 8'h00;
  localparam logic [7:0] CSL_OFF_FLAG = 8'h04;
  localparam logic [7:0] CSL_OFF_TXD = 8'h08;
  localparam logic [7:0] CSL_OFF_RXD = 8'h0c;
  localparam logic [7:0] CSL_OFF_STAT = 8'h10;
  // global control: reset value, release value, run bit positions
  localparam logic [31:0] CSL_GCTL_RST = 32'h0000_0000;
  localparam logic [31:0] CSL_GCTL_RELEASE = 32'h0e17_0300;
  localparam int CSL_GCTL_TXRUN_BIT = 27;
  localparam int CSL_GCTL_RXRUN_BIT = 26;
  // flag i/o: reset value, field positions, codec reset and release values
  localparam logic [2:0] CSL_FLAG_RST = 3'h0;
  localparam int CSL_FLAG_OE_BIT = 1;
  localparam int CSL_FLAG_VAL_BIT = 2;
  localparam logic [31:0] CSL_FLAG_ASSERT = 32'h0000_0002;
  localparam logic [31:0] CSL_FLAG_RELEASE = 32'h0000_0006;
  // low bits of a word that announce a control word next
  localparam logic [1:0] CSL_ESCAPE = 2'h3;
  // per-direction shifter state
  typedef enum logic {
    CSL_IDLE = 1'b0,
    CSL_SHIFT = 1'b1
  } csl_shift_type;
  // link pins sampled on the link clock
  typedef struct packed {
    logic txFsN;
    logic rxFsN;
    logic rxBit;
  } csl_pins_type;
  // status word, low bits of the status register
  typedef struct packed {
    logic [1:0] ctrlType;
    logic ctrlNext;
    logic rxEnd;
    logic txEnd;
    logic rxFull;
    logic txFull;
  } csl_status_type;
endpackage

// *** hdl/csl_sync.sv ***
`timescale 1ns/1ps
// two-flop level synchroniser; stage one feeds stage two only
module csl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] async,
  output logic [W-1:0] sync
);
  // first stage, may go metastable
  logic [W-1:0] stage_reg;

  // no reset: the stages settle within two edges
  always_ff @(posedge clk) begin
    stage_reg <= async;
    sync <= stage_reg;
  end
endmodule

// *** hdl/csl_link_shifter.sv ***
`timescale 1ns/1ps
// link-clock shifters, one per direction, running independently
module csl_link_shifter import csl_pkg::*; #(
  parameter int W = CSL_WORD_W
) (
  input wire logic linkClk,
  input wire logic txRunAsync,
  input wire logic rxRunAsync,
  input wire logic [W-1:0] txWord,
  input csl_pins_type pins,
  output logic txSerialOut,
  output logic txDoneTgl,
  output logic rxDoneTgl,
  output logic [W-1:0] rxWord
);
  localparam int CW = $clog2(W) + 1;
  // run levels from the core domain
  logic [1:0] runLink;
  csl_shift_type txState_reg, rxState_reg;
  logic [CW-1:0] txCnt_reg, rxCnt_reg;
  logic [W-1:0] txShift_reg, rxShift_reg;
  // previous frame-sync levels, to find falling edges
  logic txFsPrev_reg, rxFsPrev_reg;

  csl_sync #(.W(2)) runSync (
    .clk(linkClk),
    .async({txRunAsync, rxRunAsync}),
    .sync(runLink)
  );

  wire txStart = runLink[1] && txState_reg == CSL_IDLE && txFsPrev_reg && !pins.txFsN;
  wire rxStart = runLink[0] && rxState_reg == CSL_IDLE && rxFsPrev_reg && !pins.rxFsN;

  // edge history of the frame syncs
  always_ff @(posedge linkClk) begin
    txFsPrev_reg <= pins.txFsN;
    rxFsPrev_reg <= pins.rxFsN;
  end

  // msb first on tx
  // the word is taken at frame start; software refills after the done event
  always_ff @(posedge linkClk) begin
    if (!runLink[1]) begin
      txState_reg <= CSL_IDLE;
      txCnt_reg <= '0;
      txShift_reg <= '0;
      txSerialOut <= 1'b0;
      txDoneTgl <= 1'b0;
    end else if (txStart) begin
      txState_reg <= CSL_SHIFT;
      txSerialOut <= txWord[W-1];
      txShift_reg <= {txWord[W-2:0], 1'b0};
      txCnt_reg <= CW'(W - 1);
    end else if (txState_reg == CSL_SHIFT) begin
      txSerialOut <= txShift_reg[W-1];
      txShift_reg <= {txShift_reg[W-2:0], 1'b0};
      txCnt_reg <= txCnt_reg - 1'b1;
      if (txCnt_reg == CW'(1)) begin
        txState_reg <= CSL_IDLE;
        txDoneTgl <= ~txDoneTgl;
      end
    end
  end

  // rx runs apart from tx
  // rxWord stays still until the next word ends, so the core may copy it
  always_ff @(posedge linkClk) begin
    if (!runLink[0]) begin
      rxState_reg <= CSL_IDLE;
      rxCnt_reg <= '0;
      rxShift_reg <= '0;
      rxWord <= '0;
      rxDoneTgl <= 1'b0;
    end else if (rxStart) begin
      rxState_reg <= CSL_SHIFT;
      rxShift_reg <= {rxShift_reg[W-2:0], pins.rxBit};
      rxCnt_reg <= CW'(W - 1);
    end else if (rxState_reg == CSL_SHIFT) begin
      rxShift_reg <= {rxShift_reg[W-2:0], pins.rxBit};
      rxCnt_reg <= rxCnt_reg - 1'b1;
      if (rxCnt_reg == CW'(1)) begin
        rxState_reg <= CSL_IDLE;
        rxWord <= {rxShift_reg[W-2:0], pins.rxBit};
        rxDoneTgl <= ~rxDoneTgl;
      end
    end
  end

  // one word per tx frame
  tx_word_len_a: assert property (@(posedge linkClk) disable iff (!runLink[1])
    txStart |-> ##15 (txCnt_reg == CW'(1)) ##1 $changed(txDoneTgl))
    else $error("tx word did not take sixteen link clocks");
  // one word per rx frame
  rx_word_len_a: assert property (@(posedge linkClk) disable iff (!runLink[0])
    rxStart |-> ##15 (rxCnt_reg == CW'(1)) ##1 $changed(rxDoneTgl))
    else $error("rx word did not take sixteen link clocks");
endmodule

// *** hdl/csl_serial_port.sv ***
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module csl_serial_port import csl_pkg::*; #(
  parameter int WORD_W = CSL_WORD_W
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic linkClk,
  input wire logic txFrameSyncN,
  input wire logic rxFrameSyncN,
  input wire logic rxSerialIn,
  output logic txSerialOut,
  input wire logic txEndPulseN,
  input wire logic rxEndPulseN,
  output logic flagOut0,
  output logic flagOut0Oe,
  output logic txDoneIrq,
  output logic rxDoneIrq
);
  // register address match
  // shared by every hit line so all decodes compare the same way
  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] off);
    regHit = (addr == off);
  endfunction

  // software-visible state
  logic [31:0] gctl_reg;
  logic [2:0] flag_reg;
  logic [WORD_W-1:0] txBuf_reg;
  logic [WORD_W-1:0] rxBuf_reg;
  csl_status_type stat_reg;
  csl_status_type stat_next;
  // synchronised link events and their previous values
  logic [3:0] coreSync;
  logic [3:0] corePrev_reg;
  // link-domain results
  logic txDoneTgl;
  logic rxDoneTgl;
  logic [WORD_W-1:0] rxWordLink;
  csl_pins_type linkPins;

  // apb phase decode
  wire setupPhase = psel && !penable;
  wire accessDone = psel && penable && pready;
  wire wrDone = accessDone && pwrite;
  wire rdDone = accessDone && !pwrite;

  // one hit line per register
  wire hitGctl = regHit(paddr, CSL_OFF_GCTL);
  wire hitFlag = regHit(paddr, CSL_OFF_FLAG);
  wire hitTx = regHit(paddr, CSL_OFF_TXD);
  wire hitRx = regHit(paddr, CSL_OFF_RXD);
  wire hitStat = regHit(paddr, CSL_OFF_STAT);
  wire hitAny = hitGctl || hitFlag || hitTx || hitRx || hitStat;

  // read selection, unmapped reads return zero
  wire [31:0] readValue =
    hitGctl ? gctl_reg :
    hitFlag ? {29'h0, flag_reg} :
    hitTx ? {{(32 - WORD_W){1'b0}}, txBuf_reg} :
    hitRx ? {{(32 - WORD_W){1'b0}}, rxBuf_reg} :
    hitStat ? {25'h0, stat_reg} : 32'h0;

  // run bits from the release value
  // the halt value clears both bits, which also holds the link side in reset
  wire txRun = gctl_reg[CSL_GCTL_TXRUN_BIT];
  wire rxRun = gctl_reg[CSL_GCTL_RXRUN_BIT];

  // event edges in the core domain; halted ports ignore toggles
  // a toggle crosses safely where a one-cycle pulse could fall between edges
  wire txEvent = txRun && (coreSync[3] != corePrev_reg[3]);
  wire rxEvent = rxRun && (coreSync[2] != corePrev_reg[2]);
  // end pulses are falling edges of the codec's outputs
  wire txEndFall = corePrev_reg[1] && !coreSync[1];
  wire rxEndFall = corePrev_reg[0] && !coreSync[0];

  // accesses with side effects
  wire wrTx = wrDone && hitTx;
  wire rdRx = rdDone && hitRx;
  wire wrStat = wrDone && hitStat;
  wire escWord = (pwdata[1:0] == CSL_ESCAPE);

  // pins grouped for the link side
  assign linkPins = '{txFsN: txFrameSyncN, rxFsN: rxFrameSyncN, rxBit: rxSerialIn};

  // codec picks the form
  // both shifters run apart, so sync and async frames need no setting here
  // link shifters on the link clock
  csl_link_shifter #(.W(WORD_W)) shifter (
    .linkClk(linkClk),
    .txRunAsync(txRun),
    .rxRunAsync(rxRun),
    .txWord(txBuf_reg),
    .pins(linkPins),
    .txSerialOut(txSerialOut),
    .txDoneTgl(txDoneTgl),
    .rxDoneTgl(rxDoneTgl),
    .rxWord(rxWordLink)
  );

  // toggles and end pulses cross into the core clock
  csl_sync #(.W(4)) coreSyncer (
    .clk(core_clk),
    .async({txDoneTgl, rxDoneTgl, txEndPulseN, rxEndPulseN}),
    .sync(coreSync)
  );

  // history for edge finding, ends idle high
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      corePrev_reg <= 4'h3;
    end else begin
      corePrev_reg <= coreSync;
    end
  end

  // apb answer: one setup, one access cycle, no waits
  // pslverr rides with pready so the master sees it at the access edge
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !hitAny;
      if (setupPhase) begin
        prdata <= readValue;
      end
    end
  end

  // global control holds the run bits
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gctl_reg <= CSL_GCTL_RST;
    end else if (wrDone && hitGctl) begin
      gctl_reg <= pwdata;
    end
  end

  // flag drives the codec reset
  // pin floats after reset, so the codec side needs a pull-down
  // only bits 1 and 2 act on the pin; bit 0 is kept for software
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flag_reg <= CSL_FLAG_RST;
      flagOut0Oe <= 1'b0;
      flagOut0 <= 1'b0;
    end else if (wrDone && hitFlag) begin
      flag_reg <= pwdata[2:0];
      flagOut0Oe <= pwdata[CSL_FLAG_OE_BIT];
      flagOut0 <= pwdata[CSL_FLAG_VAL_BIT];
    end
  end

  // tx buffer, written by software
  // the link copies this word at frame start without a handshake, so software
  // must only write it between a done pulse and the next frame
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      txBuf_reg <= '0;
    end else if (wrTx) begin
      txBuf_reg <= pwdata[WORD_W-1:0];
    end
  end

  // rx buffer; the link word is stable when the toggle arrives
  // it changed at least two core cycles before the event is seen here
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxBuf_reg <= '0;
    end else if (rxEvent) begin
      rxBuf_reg <= rxWordLink;
    end
  end

  // status next value
  // ctrlType keeps the kind of the last control word until the next one
  always_comb begin
    stat_next = stat_reg;
    // refill wins over the done clear
    stat_next.txFull = wrTx || (stat_reg.txFull && !txEvent);
    // new word wins over the read clear
    stat_next.rxFull = rxEvent || (stat_reg.rxFull && !rdRx);
    // end pulses stick, write one to clear, set wins
    stat_next.txEnd = txEndFall || (stat_reg.txEnd && !(wrStat && pwdata[1]));
    stat_next.rxEnd = rxEndFall || (stat_reg.rxEnd && !(wrStat && pwdata[2]));
    // an escape covers exactly one word
    if (wrTx && stat_reg.ctrlNext) begin
      stat_next.ctrlNext = 1'b0;
      stat_next.ctrlType = pwdata[1:0];
    end else if (wrTx && escWord) begin
      stat_next.ctrlNext = 1'b1;
    end
  end

  // status register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      txDoneIrq <= 1'b0;
      rxDoneIrq <= 1'b0;
    end else begin
      txDoneIrq <= txEvent;
      rxDoneIrq <= rxEvent;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // every setup is answered in the next cycle
  apb_answer_a: assert property (setupPhase |=> pready ##1 !pready)
    else $error("setup not answered in one cycle");
  // unmapped addresses report an error
  apb_unmapped_a: assert property (setupPhase && !hitAny |=> pslverr && prdata == 32'h0)
    else $error("unmapped access without error");
  // flag write of 2 puts the codec in reset
  flag_low_a: assert property (wrDone && hitFlag && pwdata == CSL_FLAG_ASSERT
    |=> flagOut0Oe && !flagOut0)
    else $error("flag not driven low");
  // flag write of 6 releases the codec
  flag_high_a: assert property (wrDone && hitFlag && pwdata == CSL_FLAG_RELEASE
    |=> flagOut0Oe && flagOut0)
    else $error("flag not driven high");
  // with both ports halted, neither raises a done pulse
  run_gate_a: assert property (!txRun && !rxRun
    |=> !txDoneIrq && !rxDoneIrq)
    else $error("done pulse while halted");
  // a received word lands with its pulse
  rx_done_a: assert property (rxEvent
    |=> rxDoneIrq && stat_reg.rxFull && rxBuf_reg == $past(rxWordLink) ##1 !rxDoneIrq)
    else $error("rx word or pulse lost");
  // an escape word arms the control flag
  escape_mark_a: assert property (wrTx && !stat_reg.ctrlNext && escWord
    |=> stat_reg.ctrlNext)
    else $error("escape not seen");
  // the armed flag is spent by one word
  escape_single_a: assert property (wrTx && stat_reg.ctrlNext
    |=> !stat_reg.ctrlNext && stat_reg.ctrlType == $past(pwdata[1:0]))
    else $error("escape covered more than one word");
  // a word with other low bits arms nothing
  ctrl_plain_a: assert property (wrTx && !stat_reg.ctrlNext && !escWord
    |=> !stat_reg.ctrlNext)
    else $error("control flag armed without escape");
  // a sent word raises one pulse and frees the buffer
  tx_done_a: assert property (txEvent && !wrTx
    |=> txDoneIrq && !stat_reg.txFull ##1 !txDoneIrq)
    else $error("tx word or pulse lost");
  // the rx buffer moves only with a received word
  rx_hold_a: assert property (!rxEvent |=> $stable(rxBuf_reg))
    else $error("rx buffer changed without a word");
  // an end pulse sets its flag, even against a clear
  end_sticky_a: assert property (txEndFall || rxEndFall
    |=> (stat_reg.txEnd || !$past(txEndFall)) && (stat_reg.rxEnd || !$past(rxEndFall)))
    else $error("end pulse flag lost");
  // a write of one clears the tx end flag when no pulse comes
  end_clear_a: assert property (wrStat && pwdata[1] && !txEndFall
    |=> !stat_reg.txEnd)
    else $error("tx end flag not cleared");

  // main scenarios
  // an escaped exchange spans a whole frame, so the window is wide
  esc_then_ctrl_c: cover property (wrTx && escWord ##[1:200] wrTx);
  tx_word_c: cover property (txDoneIrq);
  rx_word_c: cover property (rxDoneIrq && gctl_reg == CSL_GCTL_RELEASE);
  end_flags_c: cover property (stat_reg.txEnd && stat_reg.rxEnd);
endmodule

// *** verif/csl_codec_model.sv ***
`timescale 1ns/1ps
// behavioural codec on the far side of the serial link
module csl_codec_model (
  output logic linkClk,
  output logic txFrameSyncN,
  output logic rxFrameSyncN,
  output logic rxSerialIn,
  output logic txEndPulseN,
  output logic rxEndPulseN,
  input wire logic txSerialOut,
  input wire logic flagOut0,
  input wire logic flagOut0Oe
);
  logic clkRun = 1'b0; // shift clock only runs around frames
  logic ctrlNext = 1'b0; // escape seen, next word is control
  logic [1:0] lastCtrl = 2'h0; // kind of the last control word
  int nCtrl = 0; // control words taken so far
  // codec reset pin; pulled down, so a floating flag pin holds the codec in reset
  wire codecRunning = flagOut0Oe ? flagOut0 : 1'b0;

  initial begin
    linkClk = 1'b0;
    txFrameSyncN = 1'b1;
    rxFrameSyncN = 1'b1;
    rxSerialIn = 1'b0;
    txEndPulseN = 1'b1;
    rxEndPulseN = 1'b1;
  end

  // clock parks low between frames instead of running free
  always begin
    #24;
    if (clkRun || linkClk) begin
      linkClk = ~linkClk;
    end
  end

  // one word each way that is asked for; sync when both, async otherwise
  // the codec picks the form, words are always 16 bits
  task automatic frame(input logic doTx, input logic doRx, input logic [15:0] rxw,
                       output logic [15:0] txw);
    int i;
    txw = 16'h0;
    clkRun = 1'b1;
    // lead-in edges also let the link side leave its reset
    repeat (3) @(negedge linkClk);
    // while held in reset the codec starts no frame
    if (codecRunning) begin
      // frame syncs driven low by the codec
      txFrameSyncN = ~doTx;
      rxFrameSyncN = ~doRx;
      rxSerialIn = rxw[15];
      // sixteen bits, msb first, changed off the sampling edge
      for (i = 15; i >= 0; i--) begin
        @(posedge linkClk);
        @(negedge linkClk);
        txw[i] = txSerialOut;
        rxSerialIn = (i > 0) ? rxw[i - 1] : ~rxw[0];
      end
      txFrameSyncN = 1'b1;
      rxFrameSyncN = 1'b1;
      // end pulse low after sync returns high
      @(negedge linkClk);
      txEndPulseN = ~doTx;
      rxEndPulseN = ~doRx;
      @(negedge linkClk);
      txEndPulseN = 1'b1;
      rxEndPulseN = 1'b1;
      // one escape word announces exactly one control word
      if (doTx && ctrlNext) begin
        lastCtrl = txw[1:0];
        nCtrl++;
        ctrlNext = 1'b0;
      end else if (doTx) begin
        ctrlNext = (txw[1:0] == 2'h3);
      end
    end
    repeat (2) @(negedge linkClk);
    clkRun = 1'b0;
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
// bench: apb master tasks plus the codec model on the link
module tb import csl_pkg::*; ();
  logic core_clk = 1'b0; // core clock, 25 ns
  logic reset_n = 1'b0; // synchronous, active low
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic linkClk, txFrameSyncN, rxFrameSyncN, rxSerialIn, txSerialOut;
  logic txEndPulseN, rxEndPulseN, flagOut0, flagOut0Oe, txDoneIrq, rxDoneIrq;
  int fails = 0; // mismatches
  int nCompared = 0; // comparisons made
  int txIrqs = 0; // pulses seen on each interrupt
  int rxIrqs = 0;
  int expTx = 0; // pulses expected so far
  int expRx = 0;

  always #12.5 core_clk = ~core_clk;

  csl_serial_port csl_serial_port_i (.core_clk(core_clk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .linkClk(linkClk),
    .txFrameSyncN(txFrameSyncN), .rxFrameSyncN(rxFrameSyncN), .rxSerialIn(rxSerialIn),
    .txSerialOut(txSerialOut), .txEndPulseN(txEndPulseN), .rxEndPulseN(rxEndPulseN),
    .flagOut0(flagOut0), .flagOut0Oe(flagOut0Oe), .txDoneIrq(txDoneIrq),
    .rxDoneIrq(rxDoneIrq));

  csl_codec_model csl_codec_model_i (.linkClk(linkClk), .txFrameSyncN(txFrameSyncN),
    .rxFrameSyncN(rxFrameSyncN), .rxSerialIn(rxSerialIn), .txEndPulseN(txEndPulseN),
    .rxEndPulseN(rxEndPulseN), .txSerialOut(txSerialOut), .flagOut0(flagOut0),
    .flagOut0Oe(flagOut0Oe));

  // count interrupt pulses; a stuck level shows as too many
  always @(posedge core_clk) begin
    if (txDoneIrq === 1'b1) txIrqs++;
    if (rxDoneIrq === 1'b1) rxIrqs++;
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
  endtask

  // one frame through the codec; live says whether words should move
  task automatic xfer(input logic doTx, input logic doRx, input logic [15:0] tw,
                      input logic [15:0] rw, input logic live);
    logic [31:0] rd;
    logic er;
    logic [15:0] got;
    if (doTx) apb(1'b1, CSL_OFF_TXD, {16'h0, tw}, rd, er);
    csl_codec_model_i.frame(doTx, doRx, rw, got);
    // completion reaches the core a few cycles after the last bit
    repeat (10) @(posedge core_clk);
    expTx += (live && doTx);
    expRx += (live && doRx);
    chk(32'(txIrqs), 32'(expTx));
    chk(32'(rxIrqs), 32'(expRx));
    if (live && doTx) chk({16'h0, got}, {16'h0, tw});
    if (live && doRx) begin
      apb(1'b0, CSL_OFF_RXD, 32'h0, rd, er);
      chk(rd, {16'h0, rw});
    end
  endtask

  initial begin
    logic [31:0] rd;
    logic er;
    int t;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    // reset values and an unmapped address
    apb(1'b0, CSL_OFF_GCTL, 32'h0, rd, er);
    chk(rd, CSL_GCTL_RST);
    apb(1'b1, 8'h14, 32'hffff_ffff, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h14, 32'h0, rd, er);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    // codec held in reset: pin driven low, no traffic
    apb(1'b1, CSL_OFF_FLAG, CSL_FLAG_ASSERT, rd, er);
    apb(1'b0, CSL_OFF_FLAG, 32'h0, rd, er);
    chk(rd, CSL_FLAG_ASSERT);
    chk({30'h0, flagOut0Oe, flagOut0}, 32'h2);
    xfer(1'b1, 1'b1, 16'h1110, 16'h2220, 1'b0);
    // codec released, port still halted
    apb(1'b1, CSL_OFF_FLAG, CSL_FLAG_RELEASE, rd, er);
    apb(1'b0, CSL_OFF_FLAG, 32'h0, rd, er);
    chk({30'h0, flagOut0Oe, flagOut0}, 32'h3);
    xfer(1'b1, 1'b1, 16'h1110, 16'h2220, 1'b0);
    apb(1'b1, CSL_OFF_GCTL, CSL_GCTL_RELEASE, rd, er);
    apb(1'b0, CSL_OFF_GCTL, 32'h0, rd, er);
    chk(rd, CSL_GCTL_RELEASE);
    // synchronous frame, then each direction on its own
    xfer(1'b1, 1'b1, 16'h1234, 16'ha5c4, 1'b1);
    xfer(1'b1, 1'b0, 16'h4c38, 16'h0, 1'b1);
    xfer(1'b0, 1'b1, 16'h0, 16'h3ffc, 1'b1);
    // sticky end pulse flags and their write-one clear
    apb(1'b0, CSL_OFF_STAT, 32'h0, rd, er);
    chk({28'h0, rd[3:0]}, 32'hc);
    apb(1'b1, CSL_OFF_STAT, 32'h6, rd, er);
    apb(1'b0, CSL_OFF_STAT, 32'h0, rd, er);
    chk({28'h0, rd[3:0]}, 32'h0);
    // every control kind, each behind its own escape word
    for (t = 0; t < 4; t++) begin
      xfer(1'b1, 1'b0, {14'h0, CSL_ESCAPE}, 16'h0, 1'b1);
      apb(1'b0, CSL_OFF_STAT, 32'h0, rd, er);
      chk({31'h0, rd[4]}, 32'h1);
      xfer(1'b1, 1'b0, 16'h0a00 | 16'(t), 16'h0, 1'b1);
      apb(1'b0, CSL_OFF_STAT, 32'h0, rd, er);
      chk({29'h0, rd[6:4]}, 32'(t * 2));
      chk({30'h0, csl_codec_model_i.lastCtrl}, 32'(t));
    end
    // codec put back in reset stops traffic again
    apb(1'b1, CSL_OFF_FLAG, CSL_FLAG_ASSERT, rd, er);
    xfer(1'b1, 1'b1, 16'h5550, 16'h6660, 1'b0);
    report_and_stop();
  end
endmodule
